/* hw/rsq_pkg.sv */
// Constants shared by the reset sequencer and its RC tick divider.
// Assumes a single 40 MHz system clock; all other rates arrive as enables.
package rsq_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned EXT_MIN_LOW_NS = 200;
   // Shortest accepted low time rounds down, so a legal 200 ns pulse always resets
   localparam int unsigned FILT_CYC = (EXT_MIN_LOW_NS / CLK_PERIOD_NS < 1) ? 1 :
      EXT_MIN_LOW_NS / CLK_PERIOD_NS;
   localparam int unsigned RC_START_PULSES = 3;
   localparam int unsigned XTAL_EDGES = 1024;

   // ****************************************************************
   // Widths and terminal counts
   // ****************************************************************
   localparam int unsigned FILT_W = 4;
   localparam int unsigned XCNT_W = 10;
   localparam int unsigned RCNT_W = 2;
   localparam int unsigned DIV_W = 8;
   localparam logic [FILT_W-1:0] FILT_MAX = 4'(FILT_CYC);
   localparam logic [XCNT_W-1:0] XCNT_LAST = 10'(XTAL_EDGES - 1);
   localparam logic [RCNT_W-1:0] RCNT_DONE = 2'(RC_START_PULSES);

   // ****************************************************************
   // Reset causes
   // ****************************************************************
   typedef enum logic [2:0] {
      CAUSE_POR = 3'h0,
      CAUSE_WDOG = 3'h1,
      CAUSE_PC_ROLL = 3'h2,
      CAUSE_SW = 3'h3,
      CAUSE_CORE_DIP = 3'h4,
      CAUSE_EXT_PIN = 3'h5
   } rsq_cause_t;

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_PAD_WAIT = 2'h0,
      ST_CORE_WAIT = 2'h1,
      ST_XTAL_CNT = 2'h2,
      ST_RUN = 2'h3
   } rsq_state_t;

endpackage

/* hw/rsq_rc_div.sv */
// Programmable divider from RC oscillator edges to the calibrated 1 kHz tick.
// Assumes rc_rise is a one-cycle pulse per RC rising edge, in the mclk domain.
`timescale 1ns/1ps
module rsq_rc_div (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic rc_rise,
   input wire logic [rsq_pkg::DIV_W-1:0] div_value,
   output logic tick
);

   // ****************************************************************
   // Divide counter
   // ****************************************************************
   logic [rsq_pkg::DIV_W-1:0] cnt;
   wire [rsq_pkg::DIV_W-1:0] last_cnt;
   wire wrap;

   // Zero divide is read as divide by one rather than stalling the tick
   assign last_cnt = (div_value == 8'h00) ? 8'h00 : div_value - 8'h01;
   assign wrap = rc_rise && (cnt >= last_cnt);

   // Held clear while the core is in reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         tick <= 1'b0;
      end else if (!run) begin
         cnt <= 8'h00;
         tick <= 1'b0;
      end else begin
         tick <= wrap;
         if (wrap) begin
            cnt <= 8'h00;
         end else if (rc_rise) begin
            cnt <= cnt + 8'h01;
         end
      end
   end

endmodule

/* hw/rsq_reset_seq.sv */
// Chip reset sequencer: pin glitch filter, pad and core supply sequencing,
// crystal edge count before core release, and last-reset-cause log.
// Assumes all inputs synchronous to mclk; xtal_tick pulses once per crystal edge.
//
// Contract
// - Pin held low over 200 ns resets device; source holds it that long.
// - Pin passes a glitch filter; short low pulses cause no reset.
// - While reset is asserted, visible registers sit at reset values.
// - Each reset records its source in a cause register readable afterwards.
// - Causes: power-on, watchdog, PC rollover, software request, core supply dip.
// - Pad domain held in reset until pad supply good and three RC pulses.
// - Core held in reset while the core supply is below threshold.
// - After core supply good, count 1024 crystal edges before core release.
// - RC clock runs always; undivided, it clocks chip management logic (mgmt_clk held low while rst_n is low).
// - RC clock divided to 1 kHz by software-set divider for sleep timer.
`timescale 1ns/1ps
module rsq_reset_seq (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ext_reset_low,
   input wire logic pads_supply_good,
   input wire logic core_supply_good,
   input wire logic rc_clk,
   input wire logic xtal_tick,
   input wire logic wdog_expire,
   input wire logic pc_rollover,
   input wire logic sw_reset_req,
   input wire logic [rsq_pkg::DIV_W-1:0] div_value,
   output logic pad_reset_low,
   output logic core_reset_low,
   output rsq_pkg::rsq_cause_t reset_cause,
   output logic mgmt_clk,
   output logic tick_1khz
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   rsq_pkg::rsq_state_t state;
   rsq_pkg::rsq_state_t next_state;
   rsq_pkg::rsq_cause_t next_cause;
   logic [rsq_pkg::FILT_W-1:0] filt_cnt;
   logic [rsq_pkg::XCNT_W-1:0] xcnt;
   logic [rsq_pkg::RCNT_W-1:0] rcnt;
   logic rc_prev;
   logic core_good_prev;

   // ****************************************************************
   // Decoding
   // ****************************************************************
   wire rc_rise;
   wire ext_hit;
   wire ext_held;
   wire core_dip;
   wire rc_ready;
   wire xtal_done;
   wire sw_event;

   assign rc_rise = rc_clk && !rc_prev;
   // Reset fires only on the FILT_CYC-th consecutive low sample
   assign ext_hit = !ext_reset_low && (filt_cnt == rsq_pkg::FILT_MAX - 4'h1);
   assign ext_held = !ext_reset_low && (filt_cnt >= rsq_pkg::FILT_MAX - 4'h1);
   assign core_dip = core_good_prev && !core_supply_good;
   assign rc_ready = (rcnt == rsq_pkg::RCNT_DONE);
   assign xtal_done = xtal_tick && (xcnt == rsq_pkg::XCNT_LAST);
   assign sw_event = wdog_expire || pc_rollover || sw_reset_req;

   // Event-to-cause priority; supply loss outranks anything software did
   assign next_cause = !pads_supply_good ? rsq_pkg::CAUSE_POR :
      core_dip ? rsq_pkg::CAUSE_CORE_DIP :
      ext_hit ? rsq_pkg::CAUSE_EXT_PIN :
      wdog_expire ? rsq_pkg::CAUSE_WDOG :
      pc_rollover ? rsq_pkg::CAUSE_PC_ROLL :
      rsq_pkg::CAUSE_SW;

   // ****************************************************************
   // Sequencer next state
   // ****************************************************************
   always_comb begin
      next_state = state;
      case (state)
         rsq_pkg::ST_PAD_WAIT: begin
            if (pads_supply_good && rc_ready) begin
               next_state = rsq_pkg::ST_CORE_WAIT;
            end
         end
         rsq_pkg::ST_CORE_WAIT: begin
            // Pin must not be held low (ext_held) before release proceeds; a short low does not block it
            if (core_supply_good && !ext_held) begin
               next_state = rsq_pkg::ST_XTAL_CNT;
            end
         end
         rsq_pkg::ST_XTAL_CNT: begin
            if (!core_supply_good || ext_held) begin
               next_state = rsq_pkg::ST_CORE_WAIT;
            end else if (xtal_done) begin
               next_state = rsq_pkg::ST_RUN;
            end
         end
         rsq_pkg::ST_RUN: begin
            if (!core_supply_good || ext_hit || sw_event) begin
               next_state = rsq_pkg::ST_CORE_WAIT;
            end
         end
         default: next_state = rsq_pkg::ST_PAD_WAIT;
      endcase
      // Pad supply loss drops everything back to the start
      if (!pads_supply_good) begin
         next_state = rsq_pkg::ST_PAD_WAIT;
      end
   end

   // ****************************************************************
   // State, reset outputs and management clock
   // ****************************************************************
   // Outputs come from flops so release always lands on an mclk edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= rsq_pkg::ST_PAD_WAIT;
         pad_reset_low <= 1'b0;
         core_reset_low <= 1'b0;
         rc_prev <= 1'b1; // Half-seen RC pulse at release is not counted
         mgmt_clk <= 1'b0;
         core_good_prev <= 1'b0;
      end else begin
         state <= next_state;
         pad_reset_low <= (next_state != rsq_pkg::ST_PAD_WAIT);
         core_reset_low <= (next_state == rsq_pkg::ST_RUN);
         rc_prev <= rc_clk;
         mgmt_clk <= rc_clk;
         core_good_prev <= core_supply_good;
      end
   end

   // ****************************************************************
   // Pin filter and start-up counters
   // ****************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         filt_cnt <= 4'h0;
         rcnt <= 2'h0;
         xcnt <= 10'h000;
      end else begin
         // Any high sample restarts the low run, which kills glitches
         if (ext_reset_low) begin
            filt_cnt <= 4'h0;
         end else if (filt_cnt != rsq_pkg::FILT_MAX) begin
            filt_cnt <= filt_cnt + 4'h1;
         end
         if (state != rsq_pkg::ST_PAD_WAIT) begin
            rcnt <= 2'h0;
         end else if (rc_rise && !rc_ready) begin
            rcnt <= rcnt + 2'h1;
         end
         if (state != rsq_pkg::ST_XTAL_CNT) begin
            xcnt <= 10'h000;
         end else if (xtal_tick) begin
            xcnt <= xcnt + 10'h001;
         end
      end
   end

   // ****************************************************************
   // Cause log
   // ****************************************************************
   // Written only on entry to reset, so it survives for software to read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reset_cause <= rsq_pkg::CAUSE_POR;
      end else if (state != rsq_pkg::ST_PAD_WAIT &&
                   next_state != state &&
                   (next_state == rsq_pkg::ST_PAD_WAIT ||
                    next_state == rsq_pkg::ST_CORE_WAIT)) begin
         reset_cause <= next_cause;
      end
   end

   // ****************************************************************
   // Calibrated tick
   // ****************************************************************
   rsq_rc_div u_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(core_reset_low),
      .rc_rise(rc_rise),
      .div_value(div_value),
      .tick(tick_1khz)
   );

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_pin_reset;
      @(posedge mclk) disable iff (!rst_n)
      (!ext_reset_low) [*8] |=> !core_reset_low;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("long pin low missed");

   property p_glitch;
      @(posedge mclk) disable iff (!rst_n)
      (state == rsq_pkg::ST_RUN && filt_cnt < rsq_pkg::FILT_MAX - 4'h2 && pads_supply_good
       && core_supply_good && !sw_event) |=> core_reset_low;
   endproperty
   a_glitch: assert property (p_glitch) else $error("short pin low reset core");

   property p_tick_quiet;
      @(posedge mclk) disable iff (!rst_n)
      !core_reset_low |=> !tick_1khz;
   endproperty
   a_tick_quiet: assert property (p_tick_quiet) else $error("tick during reset");

   property p_wdog_cause;
      @(posedge mclk) disable iff (!rst_n)
      (state == rsq_pkg::ST_RUN && wdog_expire && pads_supply_good && core_supply_good
       && !core_dip && !ext_hit) |=> reset_cause == rsq_pkg::CAUSE_WDOG;
   endproperty
   a_wdog_cause: assert property (p_wdog_cause) else $error("watchdog not logged");

   property p_dip_cause;
      @(posedge mclk) disable iff (!rst_n)
      (state == rsq_pkg::ST_RUN && core_dip && pads_supply_good)
      |=> reset_cause == rsq_pkg::CAUSE_CORE_DIP ##1 !core_reset_low;
   endproperty
   a_dip_cause: assert property (p_dip_cause) else $error("core dip not logged");

   property p_pad_hold;
      @(posedge mclk) disable iff (!rst_n)
      $rose(pad_reset_low) |-> $past(pads_supply_good) && $past(rcnt) == rsq_pkg::RCNT_DONE;
   endproperty
   a_pad_hold: assert property (p_pad_hold) else $error("pad release early");

   property p_core_hold;
      @(posedge mclk) disable iff (!rst_n)
      !core_supply_good |=> !core_reset_low;
   endproperty
   a_core_hold: assert property (p_core_hold) else $error("core out of reset");

   property p_xtal;
      @(posedge mclk) disable iff (!rst_n)
      $rose(core_reset_low) |-> $past(xcnt) == rsq_pkg::XCNT_LAST && $past(xtal_tick);
   endproperty
   a_xtal: assert property (p_xtal) else $error("core release before 1024 edges");

   property p_mgmt;
      @(posedge mclk) disable iff (!rst_n)
      ##1 mgmt_clk == $past(rc_clk);
   endproperty
   a_mgmt: assert property (p_mgmt) else $error("management clock not RC");

   property p_tick_pulse;
      @(posedge mclk) disable iff (!rst_n)
      tick_1khz |-> $past(rc_rise) ##1 !tick_1khz;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick not an RC pulse");

   property p_release_sync;
      @(posedge mclk) disable iff (!rst_n)
      // A short glitch may still be low here; only a held pin must block release
      $rose(core_reset_low) |-> $past(ext_reset_low) ||
         $past(filt_cnt) < (rsq_pkg::FILT_MAX - 4'h1);
   endproperty
   a_release_sync: assert property (p_release_sync) else $error("release with pin low");

   property p_cause_hold;
      @(posedge mclk) disable iff (!rst_n)
      $changed(reset_cause) |-> !core_reset_low;
   endproperty
   a_cause_hold: assert property (p_cause_hold) else $error("cause changed in run");

   c_boot: cover property (@(posedge mclk) disable iff (!rst_n) $rose(core_reset_low));
   c_pin: cover property (@(posedge mclk) disable iff (!rst_n) ext_hit);
   c_sw: cover property (@(posedge mclk) disable iff (!rst_n)
      reset_cause == rsq_pkg::CAUSE_SW && core_reset_low);
   c_tick: cover property (@(posedge mclk) disable iff (!rst_n) tick_1khz);

endmodule

/* tb/rsq_far_model.sv */
// Far-side model: RC oscillator and crystal edge source for the sequencer.
// Assumes the bench enables each source; rc_clk and xtal_tick change on falling mclk, counts on rising.
`timescale 1ns/1ps
module rsq_far_model (
   input wire logic mclk,
   input wire logic rc_en,
   input wire logic xtal_en,
   output logic rc_clk,
   output logic xtal_tick,
   output int rc_rises,
   output int xtal_ticks
);
   // ****
   // Sources
   // ****
   int ph;
   logic rc_q;
   initial begin
      ph = 0;
      rc_clk = 1'b0;
      rc_q = 1'b0;
      xtal_tick = 1'b0;
      rc_rises = 0;
      xtal_ticks = 0;
   end
   // RC half period cut to 4 cycles, else one period costs 4000 cycles
   always @(negedge mclk) begin
      ph <= (ph + 1) % 4;
      if (rc_en && ph == 3) begin
         rc_clk <= ~rc_clk;
      end
      xtal_tick <= xtal_en & ~xtal_tick;  // Every other cycle, never back to back
   end
   // Counts what the sequencer sees, sampled on the same edge
   always @(posedge mclk) begin
      rc_q <= rc_clk;
      if (rc_clk && !rc_q) begin
         rc_rises <= rc_rises + 1;
      end
      if (xtal_tick) begin
         xtal_ticks <= xtal_ticks + 1;
      end
   end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the reset sequencer.
// Assumes the far-side model supplies RC and crystal edges.
`timescale 1ns/1ps
module tb_top;
   // ****
   // Signals
   // ****
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ext_reset_low = 1'b1;
   logic pads_supply_good = 1'b0;
   logic core_supply_good = 1'b0;
   logic wdog_expire = 1'b0;
   logic pc_rollover = 1'b0;
   logic sw_reset_req = 1'b0;
   logic [rsq_pkg::DIV_W-1:0] div_value = 8'h03;
   logic rc_en = 1'b0;
   logic xtal_en = 1'b0;
   logic rc_clk, xtal_tick, pad_reset_low, core_reset_low, mgmt_clk, tick_1khz;
   rsq_pkg::rsq_cause_t reset_cause;
   int rc_rises, xtal_ticks;
   int n_fail = 0;
   int tests_run = 0;
   always #12.5 mclk = ~mclk;
   rsq_reset_seq u_rsq_reset_seq (.mclk(mclk), .rst_n(rst_n),
      .ext_reset_low(ext_reset_low), .pads_supply_good(pads_supply_good),
      .core_supply_good(core_supply_good), .rc_clk(rc_clk), .xtal_tick(xtal_tick),
      .wdog_expire(wdog_expire), .pc_rollover(pc_rollover), .sw_reset_req(sw_reset_req),
      .div_value(div_value), .pad_reset_low(pad_reset_low),
      .core_reset_low(core_reset_low), .reset_cause(reset_cause), .mgmt_clk(mgmt_clk),
      .tick_1khz(tick_1khz));
   rsq_far_model u_rsq_far_model (.mclk(mclk), .rc_en(rc_en), .xtal_en(xtal_en),
      .rc_clk(rc_clk), .xtal_tick(xtal_tick), .rc_rises(rc_rises),
      .xtal_ticks(xtal_ticks));
   // ****
   // Shared tasks
   // ****
   task automatic report_and_stop();
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Bounded wait on a reset output; a hang ends the run
   task automatic wait_out(input bit pad, input logic v);
      for (int i = 0; i < 4000; i++) begin
         if ((pad ? pad_reset_low : core_reset_low) === v) return;
         cyc(1);
      end
      n_fail++;
      $display("Error reset_wait expected %0h seen timeout", v);
      report_and_stop();
   endtask
   task automatic wait_tick();
      for (int i = 0; i < 500; i++) begin
         cyc(1);
         if (tick_1khz === 1'b1) return;
      end
      n_fail++;
      $display("Error tick_wait expected 1 seen timeout");
      report_and_stop();
   endtask
   // Crystal edges only start once the sequencer is counting
   task automatic run_core();
      int t0;
      cyc(2);
      t0 = xtal_ticks;
      xtal_en <= 1'b1;
      wait_out(1'b0, 1'b1);
      check("xtal_edges", xtal_ticks - t0, rsq_pkg::XTAL_EDGES);
      xtal_en <= 1'b0;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic pad_start();
      int r0;
      pads_supply_good <= 1'b1;
      cyc(20);
      check("pad_no_rc", pad_reset_low, 1'b0);
      r0 = rc_rises;
      rc_en <= 1'b1;
      wait_out(1'b1, 1'b1);
      check("rc_rises", rc_rises - r0, rsq_pkg::RC_START_PULSES);
   endtask
   task automatic core_start();
      xtal_en <= 1'b1;
      cyc(50);
      check("core_low_supply", core_reset_low, 1'b0);
      xtal_en <= 1'b0;
      core_supply_good <= 1'b1;
      run_core();
   endtask
   task automatic fire(input int k, input rsq_pkg::rsq_cause_t exp);
      wdog_expire <= (k == 1);
      pc_rollover <= (k == 2);
      sw_reset_req <= (k == 3);
      cyc(1);
      wdog_expire <= 1'b0;
      pc_rollover <= 1'b0;
      sw_reset_req <= 1'b0;
      cyc(2);
      check("core_on_event", core_reset_low, 1'b0);
      check("reset_cause", reset_cause, exp);
      run_core();
   endtask
   // Seven low samples is the longest glitch that must be ignored
   task automatic pin_test();
      ext_reset_low <= 1'b0;
      cyc(7);
      ext_reset_low <= 1'b1;
      cyc(5);
      check("core_after_glitch", core_reset_low, 1'b1);
      ext_reset_low <= 1'b0;
      cyc(10);
      check("core_pin_low", core_reset_low, 1'b0);
      check("cause_pin", reset_cause, rsq_pkg::CAUSE_EXT_PIN);
      ext_reset_low <= 1'b1;
      cyc(5);
      check("core_pin_release", core_reset_low, 1'b0);
      run_core();
   endtask
   task automatic dip_test();
      core_supply_good <= 1'b0;
      cyc(3);
      check("cause_dip", reset_cause, rsq_pkg::CAUSE_CORE_DIP);
      // An event while the core is already held is no new reset
      wdog_expire <= 1'b1;
      cyc(1);
      wdog_expire <= 1'b0;
      cyc(2);
      check("cause_kept", reset_cause, rsq_pkg::CAUSE_CORE_DIP);
      cyc(27);
      check("core_dip", core_reset_low, 1'b0);
      core_supply_good <= 1'b1;
      run_core();
   endtask
   task automatic tick_test(input logic [7:0] dv, input int exp);
      int r0;
      div_value <= dv;
      wait_tick();
      wait_tick();
      r0 = rc_rises;
      wait_tick();
      check("rises_per_tick", rc_rises - r0, exp);
   endtask
   task automatic mgmt_test();
      logic prev;
      for (int i = 0; i < 40; i++) begin
         @(posedge mclk);
         prev = rc_clk;
         @(negedge mclk);
         check("mgmt_clk", mgmt_clk, prev);
      end
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      cyc(1);
      check("pad_in_reset", pad_reset_low, 1'b0);
      check("cause_in_reset", reset_cause, rsq_pkg::CAUSE_POR);
      check("tick_in_reset", tick_1khz, 1'b0);
      cyc(2);
      rst_n <= 1'b1;
      pad_start();
      core_start();
      fire(1, rsq_pkg::CAUSE_WDOG);
      fire(2, rsq_pkg::CAUSE_PC_ROLL);
      fire(3, rsq_pkg::CAUSE_SW);
      pin_test();
      dip_test();
      tick_test(8'h03, 3);
      tick_test(8'h01, 1);
      tick_test(8'h00, 1);
      mgmt_test();
      pads_supply_good <= 1'b0;
      cyc(2);
      check("pad_supply_loss", pad_reset_low, 1'b0);
      check("core_supply_loss", core_reset_low, 1'b0);
      check("cause_pad_loss", reset_cause, rsq_pkg::CAUSE_POR);
      rst_n <= 1'b0;
      cyc(1);
      check("cause_por", reset_cause, rsq_pkg::CAUSE_POR);
      check("mgmt_in_reset", mgmt_clk, 1'b0);
      report_and_stop();
   end
endmodule
